// ==== rtl/dpi_edge_chan.sv ====
// One input channel: synchroniser, edge detector and configured edge select.
module dpi_edge_chan (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Field input and configuration.
    input  wire logic din,
    input  wire logic edge_sel,
    input  wire logic enable,
    // Outputs.
    output logic      level,
    output logic      event_hit
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic rise;
    logic fall;

    // Two-stage synchroniser, then one stage to detect a change.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= din;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Edge detection uses only the second and third stages.
    assign rise      = sync2_reg & ~prev_reg;
    assign fall      = ~sync2_reg & prev_reg;
    assign event_hit = enable & ((edge_sel == dpi_pkg::EDGE_FALLING) ? fall : rise);
    assign level     = sync2_reg;

endmodule : dpi_edge_chan

// ==== rtl/dpi_irq_top.sv ====
// Behaviour
// - Enable byte even address, edge byte odd.
// - Flag set to 1 on any configured edge.
// - Flags stay latched until host reads.
// - Active-low request is inverse of alarm.
// - Enable bit 1 allows channel interrupts.
// - Edge bit 0 rising, 1 falling.
// - Reading interrupt register returns and clears flags.
// - Status register at base shows input levels.
//
// The register addresses and register access over APB are this design's own decisions.
module dpi_irq_top #(
    parameter int unsigned NCH = dpi_pkg::NUM_CH
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Field inputs.
    input  wire logic [NCH-1:0] field_in,
    // Interrupt request to the CPU.
    output logic             process_irq_request_low
);

    logic [NCH-1:0] enable_reg;
    logic [NCH-1:0] edge_reg;
    logic [NCH-1:0] flag_reg;
    logic [NCH-1:0] flag_next;
    logic [NCH-1:0] level;
    logic [NCH-1:0] hit;
    logic [31:0]    prdata_next;
    logic           irq_n_reg;

    // Per-channel edge detection.
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        dpi_edge_chan u_ch (
            .mclk      (mclk),
            .rst       (rst),
            .din       (field_in[g]),
            .edge_sel  (edge_reg[g]),
            .enable    (enable_reg[g]),
            .level     (level[g]),
            .event_hit (hit[g])
        );
    end

    // Bus decode; the access phase completes in one cycle.
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire hit_st   = (paddr == dpi_pkg::ADDR_STATUS);
    wire hit_irq  = (paddr == dpi_pkg::ADDR_IRQ);
    wire hit_en   = (paddr == dpi_pkg::ADDR_ENABLE);
    wire hit_edge = (paddr == dpi_pkg::ADDR_EDGE);
    wire hit_cfg  = (paddr == dpi_pkg::ADDR_CONFIG);
    wire mapped   = hit_st | hit_irq | hit_en | hit_edge | hit_cfg;
    wire rd_irq   = rd & hit_irq;
    wire wr_en    = wr & pstrb[0] & hit_en;
    wire wr_edge  = wr & pstrb[0] & hit_edge;
    wire wr_cfg_h = wr & pstrb[1] & hit_cfg;
    wire wr_cfg_l = wr & pstrb[0] & hit_cfg;

    // A read clears only the flags that it has returned.
    // Read data were taken at the setup edge, so an edge latched at that same edge must survive the clear.
    // The returned flags still stand in prdata during the access cycle, which makes them the clear mask.
    wire [NCH-1:0] clr_mask  = rd_irq ? prdata[NCH-1:0] : '0;
    wire [NCH-1:0] kept_mask = flag_reg & ~clr_mask;

    // A read clears the flags it returns, but a new edge in that cycle still sets its flag.
    assign flag_next = kept_mask | hit;

    // Read data mux; the 16-bit word keeps enable in the high byte.
    always_comb begin
        prdata_next = '0;
        if (hit_st) begin
            prdata_next[NCH-1:0] = level;
        end else if (hit_irq) begin
            prdata_next[NCH-1:0] = flag_reg;
        end else if (hit_en) begin
            prdata_next[NCH-1:0] = enable_reg;
        end else if (hit_edge) begin
            prdata_next[NCH-1:0] = edge_reg;
        end else if (hit_cfg) begin
            prdata_next[dpi_pkg::CFG_ENABLE_LSB +: NCH] = enable_reg;
            prdata_next[dpi_pkg::CFG_EDGE_LSB +: NCH]   = edge_reg;
        end
    end

    // Configuration registers.
    always_ff @(posedge mclk) begin
        if (rst) begin
            enable_reg <= dpi_pkg::ENABLE_RST;
            edge_reg   <= dpi_pkg::EDGE_RST;
        end else begin
            if (wr_en) begin
                enable_reg <= pwdata[NCH-1:0];
            end else if (wr_cfg_h) begin
                enable_reg <= pwdata[dpi_pkg::CFG_ENABLE_LSB +: NCH];
            end
            if (wr_edge) begin
                edge_reg <= pwdata[NCH-1:0];
            end else if (wr_cfg_l) begin
                edge_reg <= pwdata[dpi_pkg::CFG_EDGE_LSB +: NCH];
            end
        end
    end

    // Flags and request line.
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_reg  <= '0;
            irq_n_reg <= 1'b1;
        end else begin
            flag_reg  <= flag_next;
            irq_n_reg <= ~(|flag_next);
        end
    end

    // Bus answer registers; ready is raised for the access cycle.
    // Every access takes exactly one access cycle, so the master never sees a wait state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? prdata_next : '0;
        end
    end

    // The request line comes straight from its register.
    assign process_irq_request_low = irq_n_reg;

    // Checks.
    a_flag_sets: assert property (@(posedge mclk) disable iff (rst)
        hit != '0 |=> (flag_reg & $past(hit)) == $past(hit))
        else $error("Edge did not set its flag.");

    a_flag_holds: assert property (@(posedge mclk) disable iff (rst)
        !rd_irq |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
        else $error("Flag lost without a read.");

    a_read_clears: assert property (@(posedge mclk) disable iff (rst)
        rd_irq && hit == '0 |=> (flag_reg & $past(prdata[NCH-1:0])) == '0)
        else $error("Read did not clear flags.");

    a_irq_level: assert property (@(posedge mclk) disable iff (rst)
        process_irq_request_low == ~(|flag_reg))
        else $error("Request line disagrees with flags.");

    a_irq_release: assert property (@(posedge mclk) disable iff (rst)
        rd_irq && hit == '0 && kept_mask == '0 |=> process_irq_request_low)
        else $error("Request not released after clearing read.");

    a_disabled_quiet: assert property (@(posedge mclk) disable iff (rst)
        (hit & ~enable_reg) == '0)
        else $error("Disabled channel raised an event.");

    a_irq_readback: assert property (@(posedge mclk) disable iff (rst)
        psel && !penable && !pwrite && hit_irq |=> prdata[NCH-1:0] == $past(flag_reg))
        else $error("Interrupt read returned wrong flags.");

    a_cfg_write: assert property (@(posedge mclk) disable iff (rst)
        wr_cfg_h && !wr_en |=> enable_reg == $past(pwdata[15:8]))
        else $error("High byte did not load enable.");

    a_unread_kept: assert property (@(posedge mclk) disable iff (rst)
        rd_irq |=> (flag_reg & $past(kept_mask)) == $past(kept_mask))
        else $error("Unreturned flag lost by a read.");

    a_status_read: assert property (@(posedge mclk) disable iff (rst)
        psel && !penable && !pwrite && hit_st |=> prdata[NCH-1:0] == $past(level))
        else $error("Status read returned wrong levels.");

    a_en_write: assert property (@(posedge mclk) disable iff (rst)
        wr_en |=> enable_reg == $past(pwdata[NCH-1:0]))
        else $error("Enable byte not loaded.");

    a_edge_write: assert property (@(posedge mclk) disable iff (rst)
        wr_edge |=> edge_reg == $past(pwdata[NCH-1:0]))
        else $error("Edge byte not loaded.");

    a_cfg_edge: assert property (@(posedge mclk) disable iff (rst)
        wr_cfg_l && !wr_edge |=> edge_reg == $past(pwdata[dpi_pkg::CFG_EDGE_LSB +: NCH]))
        else $error("Low byte did not load edge select.");

    a_rd_no_write: assert property (@(posedge mclk) disable iff (rst)
        rd |=> enable_reg == $past(enable_reg) && edge_reg == $past(edge_reg))
        else $error("Read changed the configuration.");

    // Bus answer checks.
    a_ready_setup: assert property (@(posedge mclk) disable iff (rst) // Answer after setup.
        psel && !penable |=> pready)
        else $error("Ready missing after setup.");

    a_ready_pulse: assert property (@(posedge mclk) disable iff (rst) // One-cycle answer.
        pready |=> !pready)
        else $error("Ready stood longer than one cycle.");

    a_rdata_idle: assert property (@(posedge mclk) disable iff (rst) // Quiet read data.
        !pready |-> prdata == '0)
        else $error("Read data driven outside the answer.");

    a_unmapped_err: assert property (@(posedge mclk) disable iff (rst) // Error with answer.
        pslverr |-> pready)
        else $error("Error flag without ready.");

    // Covers for the main scenarios.
    c_cfg_write: cover property (@(posedge mclk) disable iff (rst) wr_cfg_h);
    c_irq_raise: cover property (@(posedge mclk) disable iff (rst) $fell(process_irq_request_low));
    c_irq_clear: cover property (@(posedge mclk) disable iff (rst) rd_irq && flag_reg != '0);
    c_set_on_clear: cover property (@(posedge mclk) disable iff (rst) rd_irq && hit != '0);

endmodule : dpi_irq_top

// ==== shared/dpi_pkg.sv ====
package dpi_pkg;

    // Channel count of the input module.
    localparam int unsigned NUM_CH = 8;

    // Register byte addresses on the APB bus.
    // Documented layout is byte-wide: status at base, interrupt register at base + 1,
    // configuration word at base + 2 (enable, even) and base + 3 (edge, odd).
    // Offsets 0..3 are not all multiples of four, so each is an index and the byte address is four times it.
    localparam logic [7:0] IDX_STATUS  = 8'h00;
    localparam logic [7:0] IDX_IRQ     = 8'h01;
    localparam logic [7:0] IDX_ENABLE  = 8'h02;
    localparam logic [7:0] IDX_EDGE    = 8'h03;
    localparam logic [7:0] IDX_CONFIG  = 8'h04;

    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_IRQ    = 12'h004;
    localparam logic [11:0] ADDR_ENABLE = 12'h008;
    localparam logic [11:0] ADDR_EDGE   = 12'h00c;
    localparam logic [11:0] ADDR_CONFIG = 12'h010;

    // Reset values of the configuration bytes.
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] EDGE_RST   = 8'h00;

    // Edge select encoding per channel.
    localparam logic EDGE_RISING  = 1'b0;
    localparam logic EDGE_FALLING = 1'b1;

    // Field positions inside the 16-bit configuration word.
    localparam int unsigned CFG_ENABLE_LSB = 8;
    localparam int unsigned CFG_EDGE_LSB   = 0;

endpackage : dpi_pkg

// ==== verification/dpi_host_model.sv ====
// Host CPU model: APB master that sets up the module and services its interrupts.
module dpi_host_model (
    // Clock.
    input  wire logic        mclk,
    // APB master side.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    // The bus is idle at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
    end

    // Setup, then access held until pready is sampled high; released data is inverted.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer

    // Every enabled channel gets a falling edge, enable byte high, edge byte low.
    task automatic configure(input logic [7:0] en, output logic [31:0] q, output logic e);
        xfer(1'b1, dpi_pkg::ADDR_CONFIG, {16'h0000, en, en}, q, e);
    endtask : configure

    // The handler reads the interrupt register one index above the status byte.
    task automatic service(output logic [31:0] q, output logic e);
        xfer(1'b0, dpi_pkg::ADDR_IRQ, 32'h0000_0000, q, e);
    endtask : service
endmodule : dpi_host_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the process interrupt block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq_req_low, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [7:0]  field_in;
    int          n_fail, n_compared;

    dpi_irq_top #(.NCH(8)) dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .field_in(field_in),
        .process_irq_request_low(irq_req_low));
    dpi_host_model cpu (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // Clock of 100 ns period.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Register access and field stimulus helpers.
    task automatic rd(input logic [11:0] a);
        cpu.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic pin(input logic [7:0] v);
        @(posedge mclk);
        field_in <= v;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask : pin

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Watchdog against a hung handshake.
    initial begin
        #300000;
        n_fail++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        field_in = 8'hff;
        n_fail = 0;
        n_compared = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk(irq_req_low, 1);
        rd(dpi_pkg::ADDR_ENABLE);
        chk(q, 0);
        cpu.configure(8'h03, q, e);
        rd(dpi_pkg::ADDR_ENABLE);
        chk(q, 32'h0000_0003);
        rd(dpi_pkg::ADDR_EDGE);
        chk(q, 32'h0000_0003);
        rd(dpi_pkg::ADDR_STATUS);
        chk(q, 32'h0000_00ff);
        pin(8'hfe);
        chk(irq_req_low, 0);
        repeat (40) @(posedge mclk);
        chk(irq_req_low, 0);
        cpu.service(q, e);
        chk(q, 32'h0000_0001);
        @(negedge mclk);
        chk(irq_req_low, 1);
        rd(dpi_pkg::ADDR_IRQ);
        chk(q, 0);
        pin(8'hff);
        pin(8'hfb);
        rd(dpi_pkg::ADDR_IRQ);
        chk(q, 0);
        pin(8'hf8);
        cpu.service(q, e);
        chk(q, 32'h0000_0003);
        wr(dpi_pkg::ADDR_EDGE, 32'h0000_0000);
        wr(dpi_pkg::ADDR_ENABLE, 32'h0000_0010);
        pin(8'he8);
        chk(irq_req_low, 1);
        pin(8'hff);
        rd(dpi_pkg::ADDR_IRQ);
        chk(q, 32'h0000_0010);
        rd(dpi_pkg::ADDR_CONFIG);
        chk(q, 32'h0000_1000);
        rd(12'h020);
        chk(e, 1);
        chk(q, 0);
        end_of_test();
    end
endmodule : tb_top
